// >>> rtl/bcp_regs.vh
`ifndef BCP_REGS_VH
`define BCP_REGS_VH

// command opcodes, first byte of every command frame
`define BCP_OP_CRC_CLEAR  8'h3B
`define BCP_OP_DEVICE_ID  8'hE2
`define BCP_OP_CONTROL0   8'h22
`define BCP_OP_CONTROL1   8'h23
`define BCP_OP_POWER      8'h56
`define BCP_OP_IB_ADDR    8'hF6
`define BCP_OP_IB_WRITE   8'h72
`define BCP_OP_SED_CRC    8'hA2
`define BCP_OP_SECURITY   8'hCE
`define BCP_OP_USER_CODE  8'hC2
`define BCP_OP_DONE       8'h5E

// fixed words and fields
`define BCP_NO_OP_WORD    32'hFFFFFFFF
`define BCP_PREAMBLE      32'hFFFFBDB3
`define BCP_INFO_NO_CMP   24'h000000
`define BCP_INFO_CMP      24'h800000
`define BCP_IBW_FLAGS     8'hD0
`define BCP_IBW_FRAMES    16'h0001
`define BCP_COMMENT_END   8'h00
`define BCP_CTL0_MASK     32'h3FFFFFFF
`define BCP_IBA_RSVD      2'h0
`define BCP_IBA_GAP       11'h000
`define BCP_PWR_ZERO      22'h0
`define BCP_DONE_ZERO     21'h0

// frame assembly width: longest frame is 15 bytes
`define BCP_FRAME_W       120
`define BCP_PAD_88        88'h0
`define BCP_PAD_56        56'h0
`define BCP_PAD_24        24'h0
`define BCP_PAD_112       112'h0
`define BCP_PAD_40        40'h0

`endif

// >>> rtl/bcp_stream_gen.v
// What this block does
// - power frame operand is 22 zeros then one bit enabling logic power domain
// - command frames: opcode, compare flag, 23 zero bits of command info
// - init-bus-address uses opcode F6, flag clear, operand starts two zeros
// - init-bus-write opcode 72 with compare and compare-at-end flags set
// - init-bus-write sends no dummy bytes; dummy flag 1, count 0000
// - soft-error CRC frame opcode A2 with 32-bit value, else no-op word
// - security frame opcode CE, else a no-op word in its slot
// - user-code frame opcode C2, compare set, 32-bit code then 16-bit CRC
// - dummy command is four bytes of all ones
// - fields not a whole number of bytes are packed out with zero bits
// - 16-bit CRC goes out bit-reversed
// - device id frame opcode E2 with 32-bit id, or no-op if disabled
// - control register 0 is loaded with bits 31 and 30 cleared
// - stream opens with a maker signature and a terminated comment
`include "bcp_regs.vh"

module bcp_stream_gen #(
  parameter [31:0] SIGNATURE = 32'h5A5A0001  // arbitrary neutral value
) (
  input  wire         clk_sys,
  input  wire         arst_n,
  input  wire         start,
  input  wire         id_check_en,
  input  wire [31:0]  device_id,
  input  wire [31:0]  control0,
  input  wire         control1_en,
  input  wire [31:0]  control1,
  input  wire         power_en,
  input  wire         ib_en,
  input  wire [1:0]   ib_width,
  input  wire [16:0]  ib_addr,
  input  wire [71:0]  ib_data,
  input  wire [15:0]  ib_crc,
  input  wire         sed_en,
  input  wire [31:0]  sed_crc,
  input  wire         security_en,
  input  wire [31:0]  user_code_a,
  input  wire [15:0]  user_crc,
  input  wire [1:0]   done_mode,
  output wire [7:0]   out_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire         busy,
  output wire         finished
);

  // frame sequence, one state per frame slot
  localparam [4:0] ST_SIG    = 5'h00;
  localparam [4:0] ST_CMT    = 5'h01;
  localparam [4:0] ST_PRE    = 5'h02;
  localparam [4:0] ST_DUM0   = 5'h03;
  localparam [4:0] ST_CRCCLR = 5'h04;
  localparam [4:0] ST_DUM1   = 5'h05;
  localparam [4:0] ST_ID     = 5'h06;
  localparam [4:0] ST_CTL0   = 5'h07;
  localparam [4:0] ST_CTL1   = 5'h08;
  localparam [4:0] ST_PWR    = 5'h09;
  localparam [4:0] ST_IBA    = 5'h0A;
  localparam [4:0] ST_IBW    = 5'h0B;
  localparam [4:0] ST_SED    = 5'h0C;
  localparam [4:0] ST_SEC    = 5'h0D;
  localparam [4:0] ST_UC     = 5'h0E;
  localparam [4:0] ST_DONE   = 5'h0F;
  localparam [4:0] ST_DUM2   = 5'h10;
  localparam [4:0] ST_END    = 5'h11;

  // bit reversal so crc bit 0 lands in the msb position on the wire
  function [15:0] rev16;
    input [15:0] v;
    integer i;
    begin
      rev16 = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        rev16[i] = v[15 - i];
      end
    end
  endfunction

  // slot pointer, byte index and buffer state
  reg [4:0]   step_reg;
  reg [3:0]   idx_reg;
  reg         gen_reg;
  reg         busy_reg;
  reg         fin_reg;
  reg [7:0]   head_reg;
  reg [7:0]   tail_reg;
  reg [1:0]   count_reg;
  reg         valid_reg;

  // combinational view of the slot being sent
  reg [`BCP_FRAME_W-1:0] frame_w;
  reg [3:0]              len_w;
  wire [7:0]             byte_w;
  wire                   full_w;
  wire                   push_w;
  wire                   pop_w;
  wire                   last_w;

  // frame contents, left-justified, with byte count; len 0 skips the slot
  always @* begin
    frame_w = {`BCP_FRAME_W{1'b0}};
    len_w   = 4'h4;
    case (step_reg)
      ST_SIG:    frame_w = {SIGNATURE, `BCP_PAD_88};
      ST_CMT: begin
        frame_w = {`BCP_COMMENT_END, `BCP_PAD_112};
        len_w   = 4'h1;
      end
      ST_PRE:    frame_w = {`BCP_PREAMBLE, `BCP_PAD_88};
      ST_DUM0:   frame_w = {`BCP_NO_OP_WORD, `BCP_PAD_88};
      ST_CRCCLR: frame_w = {`BCP_OP_CRC_CLEAR, `BCP_INFO_NO_CMP,
                            `BCP_PAD_88};
      ST_DUM1:   frame_w = {`BCP_NO_OP_WORD, `BCP_PAD_88};
      // id slot shrinks to a 4-byte no-op word when the check is off
      ST_ID: begin
        if (id_check_en) begin
          frame_w = {`BCP_OP_DEVICE_ID, `BCP_INFO_NO_CMP, device_id,
                     `BCP_PAD_56};
          len_w   = 4'h8;
        end else begin
          frame_w = {`BCP_NO_OP_WORD, `BCP_PAD_88};
        end
      end
      // top two control bits cleared whatever the user supplies
      ST_CTL0: begin
        frame_w = {`BCP_OP_CONTROL0, `BCP_INFO_NO_CMP,
                   control0 & `BCP_CTL0_MASK, `BCP_PAD_56};
        len_w   = 4'h8;
      end
      // optional slot: nothing at all goes out when disabled
      ST_CTL1: begin
        frame_w = {`BCP_OP_CONTROL1, `BCP_INFO_NO_CMP, control1,
                   `BCP_PAD_56};
        len_w   = control1_en ? 4'h8 : 4'h0;
      end
      // operand has no info field: flag, 22 zeros, enable bit
      ST_PWR:    frame_w = {`BCP_OP_POWER, 1'b0, `BCP_PWR_ZERO, power_en,
                            `BCP_PAD_88};
      ST_IBA: begin
        frame_w = {`BCP_OP_IB_ADDR, `BCP_INFO_NO_CMP, `BCP_IBA_RSVD,
                   ib_width, `BCP_IBA_GAP, ib_addr, `BCP_PAD_56};
        len_w   = ib_en ? 4'h8 : 4'h0;
      end
      // one 72-bit frame, no dummies, crc once at the end
      ST_IBW: begin
        frame_w = {`BCP_OP_IB_WRITE, `BCP_IBW_FLAGS, `BCP_IBW_FRAMES,
                   ib_data, rev16(ib_crc)};
        len_w   = ib_en ? 4'hF : 4'h0;
      end
      // soft-error slot: a 4-byte no-op word stands in when disabled
      ST_SED: begin
        if (sed_en) begin
          frame_w = {`BCP_OP_SED_CRC, `BCP_INFO_NO_CMP, sed_crc,
                     `BCP_PAD_56};
          len_w   = 4'h8;
        end else begin
          frame_w = {`BCP_NO_OP_WORD, `BCP_PAD_88};
        end
      end
      // security slot: opcode and info only, no operand
      ST_SEC: begin
        if (security_en) begin
          frame_w = {`BCP_OP_SECURITY, `BCP_INFO_NO_CMP,
                     `BCP_PAD_88};
        end else begin
          frame_w = {`BCP_NO_OP_WORD, `BCP_PAD_88};
        end
      end
      // user code closes the checked span with its own crc
      ST_UC: begin
        frame_w = {`BCP_OP_USER_CODE, `BCP_INFO_CMP, user_code_a,
                   rev16(user_crc), `BCP_PAD_40};
        len_w   = 4'hA;
      end
      // done frame: 21 zeros then the daisy chain behaviour
      ST_DONE:   frame_w = {`BCP_OP_DONE, 1'b0, `BCP_DONE_ZERO, done_mode,
                            `BCP_PAD_88};
      // trailing dummy word closes the stream
      ST_DUM2:   frame_w = {`BCP_NO_OP_WORD, `BCP_PAD_88};
      default: begin
        frame_w = {`BCP_FRAME_W{1'b0}};
        len_w   = 4'h0;
      end
    endcase
  end

  // fields narrower than a byte are packed with zero bits, so no pad ones are added
  assign byte_w = frame_w[`BCP_FRAME_W - 1 - idx_reg * 8 -: 8];
  assign full_w = (count_reg == 2'h2);
  // push only while the slot has bytes and the buffer has room
  assign push_w = gen_reg & (len_w != 4'h0) & ~full_w;
  assign pop_w  = valid_reg & out_ready;
  assign last_w = (idx_reg == len_w - 4'h1);

  // sequencer: walks slots, stalls whenever the buffer is full except in an empty slot, which still advances
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      step_reg <= ST_SIG;
      idx_reg  <= 4'h0;
      gen_reg  <= 1'b0;
    end else if (!gen_reg) begin
      if (start && !busy_reg) begin
        step_reg <= ST_SIG;
        idx_reg  <= 4'h0;
        gen_reg  <= 1'b1;
      end
    end else if (len_w == 4'h0) begin
      // empty slot costs one idle cycle
      if (step_reg == ST_DUM2 || step_reg == ST_END) begin
        gen_reg <= 1'b0;
      end
      step_reg <= step_reg + 5'h01;
    end else if (push_w) begin
      // slot advances only once its last byte is pushed
      if (last_w) begin
        idx_reg  <= 4'h0;
        step_reg <= step_reg + 5'h01;
        if (step_reg == ST_DUM2) begin
          gen_reg <= 1'b0;
        end
      end else begin
        idx_reg <= idx_reg + 4'h1;
      end
    end
  end

  // two-entry buffer; head drives the pins so a stall loses nothing
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      head_reg  <= 8'h00;
      tail_reg  <= 8'h00;
      count_reg <= 2'h0;
      valid_reg <= 1'b0;
    end else begin
      case (count_reg)
        2'h0: begin
          if (push_w) begin
            head_reg  <= byte_w;
            count_reg <= 2'h1;
            valid_reg <= 1'b1;
          end
        end
        2'h1: begin
          // one byte held: push and pop together replace it
          if (push_w && pop_w) begin
            head_reg <= byte_w;
          end else if (push_w) begin
            tail_reg  <= byte_w;
            count_reg <= 2'h2;
          end else if (pop_w) begin
            count_reg <= 2'h0;
            valid_reg <= 1'b0;
          end
        end
        2'h2: begin
          // full: only a pop moves, tail slides into head
          if (pop_w) begin
            head_reg  <= tail_reg;
            count_reg <= 2'h1;
          end
        end
        default: begin
          count_reg <= 2'h0;
          valid_reg <= 1'b0;
        end
      endcase
    end
  end

  // busy until the last byte has left the buffer
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      fin_reg  <= 1'b0;
    end else begin
      // a start while busy is dropped with no indication
      fin_reg <= 1'b0;
      if (start && !busy_reg) begin
        busy_reg <= 1'b1;
      end else if (busy_reg && !gen_reg && count_reg == 2'h0) begin
        busy_reg <= 1'b0;
        fin_reg  <= 1'b1;
      end
    end
  end

  // pins come straight from registers
  assign out_data  = head_reg;
  assign out_valid = valid_reg;
  assign busy      = busy_reg;
  assign finished  = fin_reg;

endmodule

// >>> testbench/bcp_stream_gen_properties.sv
module bcp_stream_gen_properties (
  input wire       clk_sys,
  input wire       arst_n,
  input wire       start,
  input wire [7:0] out_data,
  input wire       out_valid,
  input wire       out_ready,
  input wire       busy,
  input wire       finished
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // accepted start and a byte waiting on the receiver
  sequence s_go;
    start && !busy;
  endsequence
  sequence s_hold;
    out_valid && !out_ready;
  endsequence
  first_byte_sig_a: assert property (s_go |-> ##2 out_valid &&
    out_data == 8'h5A) else $error("first byte not signature");
  busy_after_go_a: assert property (s_go |=> busy [*2])
    else $error("busy missing after start");
  byte_holds_a: assert property (s_hold |=> out_valid && $stable(out_data))
    else $error("byte changed before taken");
  finish_pulse_a: assert property (finished |=> !finished)
    else $error("finished longer than one cycle");
  finish_ends_a: assert property (finished |-> !busy && $past(busy))
    else $error("finished without busy falling");
  last_dummy_a: assert property (finished |-> $past(out_data) == 8'hFF)
    else $error("last byte not a dummy");
  idle_quiet_a: assert property (!busy |-> !out_valid)
    else $error("byte offered while idle");
  drop_on_take_a: assert property ($fell(out_valid) |-> $past(out_ready))
    else $error("byte withdrawn untaken");
endmodule

bind bcp_stream_gen bcp_stream_gen_properties i_props (.clk_sys(clk_sys),
  .arst_n(arst_n), .start(start), .out_data(out_data),
  .out_valid(out_valid), .out_ready(out_ready), .busy(busy),
  .finished(finished));

// >>> testbench/bcp_sink_model.sv
module bcp_sink_model (
  input  wire       clk_sys,
  input  wire       arst_n,
  input  wire [7:0] out_data,
  input  wire       out_valid,
  input  wire       stall,
  output logic      out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  logic [1:0] ph;
  // slow receiver is ready one cycle in three, exercising the buffer
  always @(negedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ph <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      out_ready <= !stall || ph == 2'h0;
    end
  end
  // every taken byte kept; no-op words taken like data
  always @(posedge clk_sys)
    if (arst_n && out_valid && out_ready) got.push_back(out_data);
endmodule

// >>> testbench/bcp_stream_gen_tb.sv
module bcp_stream_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, arst_n, start, stall, id_en, c1_en, pw_en, ib_en;
  logic sed_en, sec_en, out_ready, out_valid, busy, finished;
  logic [1:0]  mode;
  logic [7:0]  out_data;
  logic [31:0] dev_id, ctl0, ctl1, sed_crc, uc;
  logic [71:0] ib_data;
  logic [15:0] ib_crc, u_crc;
  logic [16:0] ib_addr;
  logic [7:0]  exp [$];
  int error_cnt, n_checks, cyc;
  bcp_stream_gen i_bcp_stream_gen (.clk_sys(clk_sys), .arst_n(arst_n),
    .start(start), .id_check_en(id_en), .device_id(dev_id),
    .control0(ctl0), .control1_en(c1_en), .control1(ctl1),
    .power_en(pw_en), .ib_en(ib_en), .ib_width(mode), .ib_addr(ib_addr),
    .ib_data(ib_data), .ib_crc(ib_crc), .sed_en(sed_en),
    .sed_crc(sed_crc), .security_en(sec_en), .user_code_a(uc),
    .user_crc(u_crc), .done_mode(mode), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .busy(busy),
    .finished(finished));
  bcp_sink_model i_bcp_sink_model (.clk_sys(clk_sys), .arst_n(arst_n),
    .out_data(out_data), .out_valid(out_valid), .stall(stall),
    .out_ready(out_ready));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, well above four streams at the slow rate
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic p8(input logic [7:0] b);
    exp.push_back(b);
  endtask
  task automatic p32(input logic [31:0] w);
    for (int i = 3; i >= 0; i--) p8(w[i*8 +: 8]);
  endtask
  task automatic p16r(input logic [15:0] c);
    logic [15:0] r;
    r = {<<{c}};
    p8(r[15:8]);
    p8(r[7:0]);
  endtask
  // expected byte order of a full stream for the current settings
  task automatic build;
    exp.delete();
    p32(32'h5A5A0001);
    p8(8'h00);
    p32(32'hFFFFBDB3);
    p32(32'hFFFFFFFF);
    p32(32'h3B000000);
    p32(32'hFFFFFFFF);
    if (id_en) begin p32(32'hE2000000); p32(dev_id); end
    else p32(32'hFFFFFFFF);
    p32(32'h22000000);
    p32(ctl0 & 32'h3FFFFFFF);
    if (c1_en) begin p32(32'h23000000); p32(ctl1); end
    p32({31'h2B000000, pw_en});
    if (ib_en) begin
      p32(32'hF6000000);
      p32({2'h0, mode, 11'h000, ib_addr});
      p32(32'h72D00001);
      for (int i = 8; i >= 0; i--) p8(ib_data[i*8 +: 8]);
      p16r(ib_crc);
    end
    if (sed_en) begin p32(32'hA2000000); p32(sed_crc); end
    else p32(32'hFFFFFFFF);
    p32(sec_en ? 32'hCE000000 : 32'hFFFFFFFF);
    p32(32'hC2800000);
    p32(uc);
    p16r(u_crc);
    p32({30'h17800000, mode});
    p32(32'hFFFFFFFF);
  endtask
  // one stream, with a start pulse that must be ignored mid-run
  task automatic run_stream;
    int n;
    i_bcp_sink_model.got.delete();
    @(negedge clk_sys) start = 1'b1;
    @(negedge clk_sys) start = 1'b0;
    repeat (20) @(negedge clk_sys);
    start = 1'b1;
    @(negedge clk_sys) start = 1'b0;
    n = 0;
    while (finished !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h00, finished}, 8'h01);
    chk(i_bcp_sink_model.got.size(), exp.size());
    foreach (exp[i]) chk(i_bcp_sink_model.got[i], exp[i]);
    repeat (3) @(negedge clk_sys);
    chk(i_bcp_sink_model.got.size(), exp.size());
  endtask
  initial begin
    {arst_n, start, stall, id_en, c1_en, pw_en, ib_en} = 7'h00;
    {sed_en, sec_en, mode} = 4'h0;
    ctl0 = 32'hFFFF1234;
    ctl1 = 32'h0BADF00D;
    ib_addr = 17'h1ABCD;
    ib_data = 72'hA1B2C3D4E5F6071829;
    ib_crc = 16'h0823;
    sed_crc = 32'h13572468;
    uc = 32'hCAFE0042;
    u_crc = 16'h8001;
    dev_id = 32'h01234567;
    repeat (16) @(negedge clk_sys);
    arst_n = 1'b1;
    // every done mode and bus widths 1 to 3, options switched around
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      {id_en, pw_en, stall, sec_en} = {m[0], m[0], m[0], ~m[0]};
      {c1_en, sed_en, ib_en} = {m[1], m[1], m[1] | m[0]};
      build();
      run_stream();
    end
    complete_run();
  end
endmodule
